// File: verification/sdmzp_assertions.sv
// Purpose: Port checks for sdmzp_core
// Assumes: Pins act three edges after sampling
// Notes: Bound below
`timescale 1ns/100ps
module sdmzp_chk (
  input wire i_mclk,
  input wire i_rst,
  input wire i_cs_n,
  input wire i_cke,
  input wire [9:0] i_ca_rise,
  input wire [9:0] i_ca_fall,
  input wire i_bank_active,
  input wire i_cal_resistor_present,
  input wire o_busy,
  input wire o_resetting,
  input wire o_calibrating,
  input wire o_cal_pin_enable,
  input wire o_powerdown,
  input wire o_powerdown_active,
  input wire o_buffers_enable
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_cal_busy; o_calibrating |-> o_busy; endproperty
  a_cal_busy: assert property (p_cal_busy) else $error("cal not busy");
  property p_pin; o_cal_pin_enable |-> o_calibrating; endproperty
  a_pin: assert property (p_pin) else $error("pin on idle");
  property p_buf; o_powerdown |-> !o_buffers_enable; endproperty
  a_buf: assert property (p_buf) else $error("buffers on");
  property p_rst; $rose(o_resetting) |-> $past({i_ca_fall[1:0], i_ca_rise[9:4]}, 3) == 8'h3f;
  endproperty
  a_rst: assert property (p_rst) else $error("reset no index");
  property p_dec; $rose(o_busy) |-> $past(!i_cs_n && i_ca_rise[3:0] == 4'h0, 3); endproperty
  a_dec: assert property (p_dec) else $error("busy no write");
  property p_idle; $rose(o_busy) |-> $past(!i_bank_active, 3); endproperty
  a_idle: assert property (p_idle) else $error("write bank open");
  property p_res; $rose(o_calibrating) |-> $past(i_cal_resistor_present, 3); endproperty
  a_res: assert property (p_res) else $error("cal no resistor");
  property p_pde; $rose(o_powerdown) |-> $past(!i_cke && i_cs_n, 3) && $past(i_cke, 4);
  endproperty
  a_pde: assert property (p_pde) else $error("bad entry");
  property p_pda; $rose(o_powerdown) |-> o_powerdown_active == $past(i_bank_active, 3);
  endproperty
  a_pda: assert property (p_pda) else $error("pd kind");
endmodule // sdmzp_chk
bind sdmzp_core sdmzp_chk u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n),
  .i_cke(i_cke), .i_ca_rise(i_ca_rise), .i_ca_fall(i_ca_fall), .i_bank_active(i_bank_active),
  .i_cal_resistor_present(i_cal_resistor_present), .o_busy(o_busy),
  .o_resetting(o_resetting), .o_calibrating(o_calibrating),
  .o_cal_pin_enable(o_cal_pin_enable), .o_powerdown(o_powerdown),
  .o_powerdown_active(o_powerdown_active), .o_buffers_enable(o_buffers_enable));

// File: verification/sdmzp_ctrl_model.sv
// Purpose: Controller model driving command pins
// Assumes: Pins change just after a rising edge
// Notes: Bench paces busy periods
`timescale 1ns/100ps
module sdmzp_ctrl_model (
  input wire i_mclk,
  output logic o_cs_n,
  output logic o_cke,
  output logic [9:0] o_ca_rise,
  output logic [9:0] o_ca_fall
);
  // Idle: deselected, clock enable high
  initial begin
    o_cs_n = 1'b1;
    o_cke = 1'b1;
    o_ca_rise = 10'h2a5;
    o_ca_fall = 10'h15a;
  end
  // One mode write, then no-ops
  task automatic mode_reg_write_cmd(input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    o_ca_rise <= {idx[5:0], 4'h0};
    o_ca_fall <= {d, idx[7:6]};
    @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_ca_rise <= ~o_ca_rise;
    o_ca_fall <= ~o_ca_fall;
  endtask
  // Power-down entry: clock enable low, select left high
  task automatic pd_enter;
    @(posedge i_mclk);
    o_cke <= 1'b0;
  endtask
  // Power-down exit with select high
  task automatic pd_exit;
    @(posedge i_mclk);
    o_cke <= 1'b1;
  endtask
endmodule // sdmzp_ctrl_model

// File: verification/tb_top.sv
// Purpose: Self-checking bench for sdmzp_core
// Assumes: Controller model drives command pins
// Notes: Busy cycles counted over a fixed window
`timescale 1ns/100ps
`include "sdmzp_defs.vh"
module tb_top;
  logic i_mclk = 0, i_rst = 1, i_bank_active = 0, i_cal_resistor_present = 1;
  logic [5:0] i_mode_reg_sel = 0;
  wire i_cs_n, i_cke, o_busy, o_resetting, o_calibrating, o_cal_pin_enable;
  wire o_driver_impedance_default, o_powerdown, o_powerdown_active, o_buffers_enable;
  wire o_cmd_error;
  wire [9:0] i_ca_rise, i_ca_fall;
  wire [7:0] o_mode_reg_data;
  int err_total = 0, num_checks = 0, nb, ne, np, nr, nc;
  logic [31:0] seed = 32'h8368;
  logic [7:0] idx;
  logic [7:0] codes [4] = '{`SDMZP_CAL_INITIAL_CODE, `SDMZP_CAL_LONG_CODE,
    `SDMZP_CAL_SHORT_CODE, `SDMZP_CAL_DEFAULT_CODE};
  int lens_ns [4] = '{`SDMZP_CAL_INITIAL_BUSY_NS, `SDMZP_CAL_LONG_BUSY_NS,
    `SDMZP_CAL_SHORT_BUSY_NS, `SDMZP_CAL_DEFAULT_BUSY_NS};
  // Clock
  initial begin
    forever #2 i_mclk = ~i_mclk;
  end
  sdmzp_ctrl_model u_ctrl (.i_mclk(i_mclk), .o_cs_n(i_cs_n), .o_cke(i_cke),
    .o_ca_rise(i_ca_rise), .o_ca_fall(i_ca_fall));
  sdmzp_core u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_cke(i_cke),
    .i_ca_rise(i_ca_rise), .i_ca_fall(i_ca_fall), .i_bank_active(i_bank_active),
    .i_cal_resistor_present(i_cal_resistor_present), .i_mode_reg_sel(i_mode_reg_sel),
    .o_busy(o_busy), .o_resetting(o_resetting), .o_calibrating(o_calibrating),
    .o_cal_pin_enable(o_cal_pin_enable), .o_driver_impedance_default(o_driver_impedance_default),
    .o_powerdown(o_powerdown), .o_powerdown_active(o_powerdown_active),
    .o_buffers_enable(o_buffers_enable), .o_cmd_error(o_cmd_error),
    .o_mode_reg_data(o_mode_reg_data));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Busy length in cycles: time over clock period, rounded up
  function automatic int busy_cyc(input int ns);
    return (ns + `SDMZP_CLK_PERIOD_NS - 1) / `SDMZP_CLK_PERIOD_NS;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write, then count busy, error, pin and resetting cycles
  task automatic op(input logic [7:0] i, input logic [7:0] d);
    u_ctrl.mode_reg_write_cmd(i, d);
    nb = 0;
    ne = 0;
    np = 0;
    nr = 0;
    nc = 0;
    repeat (300) begin
      @(negedge i_mclk);
      nb += (o_busy === 1'b1);
      ne += (o_cmd_error === 1'b1);
      np += (o_cal_pin_enable === 1'b1);
      nr += (o_resetting === 1'b1);
      nc += (o_calibrating === 1'b1);
    end
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    @(posedge i_mclk);
    i_mode_reg_sel <= i;
    repeat (2) @(negedge i_mclk);
    chk("mode_reg", e, o_mode_reg_data);
  endtask
  task automatic pd(input logic a);
    u_ctrl.pd_enter();
    repeat (5) @(negedge i_mclk);
    chk("pd", 1, o_powerdown);
    chk("buf_off", 0, o_buffers_enable);
    chk("pd_act", a, o_powerdown_active);
    u_ctrl.pd_exit();
    repeat (10) @(negedge i_mclk);
    chk("pd_exit", 0, o_powerdown);
    chk("buf_on", 1, o_buffers_enable);
    chk("pd_act_clr", 0, o_powerdown_active);
  endtask
  task automatic conclude;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial begin
    #60000;
    err_total++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 0;
    op(8'd62, 8'h3c);
    rd(6'd62, 8'h3c);
    repeat (3) begin
      seed = xs(seed);
      idx = 8'(seed[5:0] % 60 + 1);
      if (idx == 8'd10) idx = 8'd11;
      op(idx, seed[15:8]);
      chk("busy_mrw", busy_cyc(`SDMZP_MODE_WRITE_BUSY_NS), nb);
      chk("err_none", 0, ne);
      rd(idx[5:0], seed[15:8]);
    end
    for (int k = 0; k < 4; k++) begin
      op(8'd10, codes[k]);
      chk("cal_busy", busy_cyc(lens_ns[k]), nb);
      chk("calibrating", busy_cyc(lens_ns[k]), nc);
      chk("pin_used", k < 3, np > 0);
      chk("pin_off", 0, o_cal_pin_enable);
      chk("imp_def", k == 3, o_driver_impedance_default);
    end
    op(8'd10, 8'h00);
    chk("cal_bad_code", 0, nb);
    @(posedge i_mclk);
    i_cal_resistor_present <= 0;
    op(8'd10, `SDMZP_CAL_LONG_CODE);
    chk("cal_ignored", 0, nb);
    @(posedge i_mclk);
    i_cal_resistor_present <= 1;
    i_bank_active <= 1;
    op(8'd62, 8'h11);
    chk("busy_bank", 0, nb);
    chk("err_bank", 1, ne);
    rd(6'd62, 8'h3c);
    pd(1);
    @(posedge i_mclk);
    i_bank_active <= 0;
    pd(0);
    op(8'd63, 8'h00);
    chk("reset_len", busy_cyc(`SDMZP_RESET_INIT_BUSY_NS), nr);
    rd(6'd62, 8'h00);
    conclude();
  end
endmodule // tb_top

// File: verilog/sdmzp_core.v
// Purpose: Device-side state tracking for mode writes, write-reset, impedance
//          calibration and power-down
// Assumes: Command/address pins are already captured per edge pair; pins are
//          synchronised here by two flops before use
// Notes: One clock domain; no software registers
// What this block does
// - Mode reads accepted idle or active; bank state is kept.
// - Mode writes only with all banks idle; plain write returns idle.
// - Mode write to register 63 starts the resetting state.
// - Write-reset restores all mode registers to defaults; array undefined.
// - Calibration via mode write; four variants each with own busy time.
// - Without calibration resistor, ignore calibration commands, keep defaults.
// - After calibration completes, switch off calibration pin current.
// - Power-down entry: clock enable low, select high, previous enable high.
// - Power-down is idle if all banks idle, else active.
// - Buffers off in power-down; clock enable low for minimum pulse.
// - Mode write decoded: select and four low address bits all low.
`timescale 1ns/100ps
`include "sdmzp_defs.vh"
module sdmzp_core (
  input wire i_mclk,
  input wire i_rst,
  input wire i_cs_n,
  input wire i_cke,
  input wire [9:0] i_ca_rise,
  input wire [9:0] i_ca_fall,
  input wire i_bank_active,
  input wire i_cal_resistor_present,
  input wire [5:0] i_mode_reg_sel,
  output reg o_busy,
  output reg o_resetting,
  output reg o_calibrating,
  output reg o_cal_pin_enable,
  output reg o_driver_impedance_default,
  output reg o_powerdown,
  output reg o_powerdown_active,
  output reg o_buffers_enable,
  output reg o_cmd_error,
  output reg [7:0] o_mode_reg_data
);
  // ---------------------------------------------------------------
  // Local constants
  // ---------------------------------------------------------------
  localparam [`SDMZP_CNT_W-1:0] MW_CYC = `SDMZP_CYC(`SDMZP_MODE_WRITE_BUSY_NS);
  localparam [`SDMZP_CNT_W-1:0] RI_CYC = `SDMZP_CYC(`SDMZP_RESET_INIT_BUSY_NS);
  localparam [`SDMZP_CNT_W-1:0] CI_CYC = `SDMZP_CYC(`SDMZP_CAL_INITIAL_BUSY_NS);
  localparam [`SDMZP_CNT_W-1:0] CL_CYC = `SDMZP_CYC(`SDMZP_CAL_LONG_BUSY_NS);
  localparam [`SDMZP_CNT_W-1:0] CS_CYC = `SDMZP_CYC(`SDMZP_CAL_SHORT_BUSY_NS);
  localparam [`SDMZP_CNT_W-1:0] CD_CYC = `SDMZP_CYC(`SDMZP_CAL_DEFAULT_BUSY_NS);
  localparam [`SDMZP_CNT_W-1:0] CKE_CYC = `SDMZP_CYC(`SDMZP_CKE_MIN_PULSE_NS);
  localparam [`SDMZP_CNT_W-1:0] XP_CYC = `SDMZP_CYC(`SDMZP_PD_EXIT_LATENCY_NS);
  // One-hot states
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_MW = 6'h02;
  localparam [5:0] ST_RST = 6'h04;
  localparam [5:0] ST_CAL = 6'h08;
  localparam [5:0] ST_PD = 6'h10;
  localparam [5:0] ST_PDX = 6'h20;

  // No-op: select high, or select low with three low bits high
  function is_nop;
    input cs_n;
    input [2:0] ca;
    begin
      is_nop = cs_n | (ca == 3'h7);
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  reg [11:0] sync1;
  reg [11:0] sync2;
  reg [9:0] caf1;
  reg [9:0] caf2;
  reg [1:0] bres1;
  reg [1:0] bres2;
  // Two flops on every pin input
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      // Idle levels: enable high, deselected, so no false entry edge after reset
      sync1 <= 12'h801;
      sync2 <= 12'h801;
      caf1 <= 10'h000;
      caf2 <= 10'h000;
      bres1 <= 2'h0;
      bres2 <= 2'h0;
    end else begin
      sync1 <= {i_cke, i_ca_rise, i_cs_n};
      sync2 <= sync1;
      caf1 <= i_ca_fall;
      caf2 <= caf1;
      bres1 <= {i_bank_active, i_cal_resistor_present};
      bres2 <= bres1;
    end
  end
  wire cke = sync2[11];
  wire [9:0] ca_r = sync2[10:1];
  wire cs_n = sync2[0];
  wire bank_act = bres2[1];
  wire res_ok = bres2[0];

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  reg cke_prev;
  wire cmd_ok = cke & cke_prev;
  wire mw_cmd = cmd_ok & ~cs_n & (ca_r[3:0] == 4'h0);
  wire [7:0] mw_idx = {caf2[1:0], ca_r[9:4]};
  wire [7:0] mw_data = caf2[9:2];
  wire pd_entry = ~cke & cke_prev & cs_n;
  wire nop = is_nop(cs_n, ca_r[2:0]);
  wire cal_cmd = mw_cmd & (mw_idx == `SDMZP_CAL_CMD_REG_INDEX);
  wire cal_code_ok = (mw_data == `SDMZP_CAL_INITIAL_CODE) |
    (mw_data == `SDMZP_CAL_LONG_CODE) | (mw_data == `SDMZP_CAL_SHORT_CODE) |
    (mw_data == `SDMZP_CAL_DEFAULT_CODE);

  // Calibration busy length per variant
  reg [`SDMZP_CNT_W-1:0] cal_len;
  always @* begin
    case (mw_data)
      `SDMZP_CAL_INITIAL_CODE: cal_len = CI_CYC;
      `SDMZP_CAL_LONG_CODE: cal_len = CL_CYC;
      `SDMZP_CAL_SHORT_CODE: cal_len = CS_CYC;
      default: cal_len = CD_CYC;
    endcase
  end

  // ---------------------------------------------------------------
  // Mode register storage
  // ---------------------------------------------------------------
  reg [7:0] mode_reg [0:`SDMZP_NUM_MODE_REGS-1];
  reg [5:0] state;
  wire do_reset = (state == ST_IDLE) & mw_cmd & ~bank_act &
    (mw_idx == `SDMZP_RESET_REG_INDEX);
  wire do_write = (state == ST_IDLE) & mw_cmd & ~bank_act & ~do_reset & ~cal_cmd;
  genvar g;
  generate
    for (g = 0; g < `SDMZP_NUM_MODE_REGS; g = g + 1) begin : g_mr
      always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          mode_reg[g] <= `SDMZP_MODE_REG_DEFAULT;
        end else if (do_reset) begin
          mode_reg[g] <= `SDMZP_MODE_REG_DEFAULT;
        end else if (do_write && mw_idx == g) begin
          mode_reg[g] <= mw_data;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Main state machine
  // ---------------------------------------------------------------
  reg [`SDMZP_CNT_W-1:0] cnt;
  reg cal_quiet;
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      cnt <= {`SDMZP_CNT_W{1'b0}};
      cke_prev <= 1'b1;
      cal_quiet <= 1'b0;
      o_busy <= 1'b0;
      o_resetting <= 1'b0;
      o_calibrating <= 1'b0;
      o_cal_pin_enable <= 1'b0;
      o_driver_impedance_default <= 1'b1;
      o_powerdown <= 1'b0;
      o_powerdown_active <= 1'b0;
      o_buffers_enable <= 1'b1;
      o_cmd_error <= 1'b0;
      o_mode_reg_data <= 8'h00;
    end else begin
      cke_prev <= cke;
      o_cmd_error <= 1'b0;
      o_mode_reg_data <= mode_reg[i_mode_reg_sel];
      case (state)
        ST_IDLE: begin
          if (pd_entry) begin
            state <= ST_PD;
            cnt <= CKE_CYC;
            o_powerdown <= 1'b1;
            o_powerdown_active <= bank_act;
            o_buffers_enable <= 1'b0;
          end else if (mw_cmd && bank_act) begin
            o_cmd_error <= 1'b1;
          end else if (do_reset) begin
            state <= ST_RST;
            cnt <= RI_CYC;
            o_busy <= 1'b1;
            o_resetting <= 1'b1;
            o_driver_impedance_default <= 1'b1;
          end else if (cal_cmd) begin
            if (res_ok && cal_code_ok) begin
              state <= ST_CAL;
              cnt <= cal_len;
              o_busy <= 1'b1;
              o_calibrating <= 1'b1;
              o_cal_pin_enable <= (mw_data != `SDMZP_CAL_DEFAULT_CODE);
              cal_quiet <= (mw_data != `SDMZP_CAL_DEFAULT_CODE);
            end
            // Without a resistor the command is ignored
          end else if (do_write) begin
            state <= ST_MW;
            cnt <= MW_CYC;
            o_busy <= 1'b1;
          end
        end
        ST_MW, ST_RST, ST_CAL: begin
          // Flag non-no-op commands while busy, or enable drops while calibrating
          if (~nop && cmd_ok) begin
            o_cmd_error <= 1'b1;
          end
          if (state == ST_CAL && ~cke) begin
            o_cmd_error <= 1'b1;
          end
          if (cnt <= 16'h0001) begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
            o_resetting <= 1'b0;
            o_calibrating <= 1'b0;
            o_cal_pin_enable <= 1'b0;
            if (state == ST_CAL) begin
              o_driver_impedance_default <= ~cal_quiet;
            end
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_PD: begin
          if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
          end
          if (cke && cs_n && cnt <= 16'h0001) begin
            state <= ST_PDX;
            cnt <= XP_CYC;
            o_powerdown <= 1'b0;
            o_buffers_enable <= 1'b1;
          end else if (cke) begin
            o_cmd_error <= 1'b1;
          end
        end
        ST_PDX: begin
          if (~nop || ~cke) begin
            o_cmd_error <= 1'b1;
          end
          if (cnt <= 16'h0001) begin
            state <= ST_IDLE;
            o_powerdown_active <= 1'b0;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // sdmzp_core

// File: verilog/sdmzp_defs.vh
// Purpose: Constants for the mode-write, calibration and power-down command block
// Assumes: Core clock 250 MHz (4 ns); busy times given in ns
// Notes: Cycle counts derive from time and clock period, rounded up
`ifndef SDMZP_DEFS_VH
`define SDMZP_DEFS_VH
`define SDMZP_CLK_PERIOD_NS 4
// Busy times in ns (plain defaults where no figure is given)
`define SDMZP_MODE_WRITE_BUSY_NS 20
`define SDMZP_RESET_INIT_BUSY_NS 1000
`define SDMZP_CAL_INITIAL_BUSY_NS 1000
`define SDMZP_CAL_LONG_BUSY_NS 360
`define SDMZP_CAL_SHORT_BUSY_NS 90
`define SDMZP_CAL_DEFAULT_BUSY_NS 50
`define SDMZP_CKE_MIN_PULSE_NS 12
`define SDMZP_PD_EXIT_LATENCY_NS 8
`define SDMZP_CYC(t) (((t) + `SDMZP_CLK_PERIOD_NS - 1) / `SDMZP_CLK_PERIOD_NS)
// Field widths: command/address word, register index, data, busy counter
`define SDMZP_CA_W 10
`define SDMZP_REG_INDEX_W 8
`define SDMZP_DATA_W 8
`define SDMZP_CNT_W 16
// Register indices and calibration codes
`define SDMZP_RESET_REG_INDEX 8'h3f
`define SDMZP_CAL_CMD_REG_INDEX 8'h0a
`define SDMZP_CAL_INITIAL_CODE 8'hff
`define SDMZP_CAL_LONG_CODE 8'hab
`define SDMZP_CAL_SHORT_CODE 8'h56
`define SDMZP_CAL_DEFAULT_CODE 8'hc3
`define SDMZP_NUM_MODE_REGS 64
`define SDMZP_MODE_REG_DEFAULT 8'h00
`endif
